// file: verilog/asac_consts.svh
`ifndef ASAC_CONSTS_SVH
`define ASAC_CONSTS_SVH
// Byte addresses of the two host locations
`define ASAC_CTRL_STAT_OFS 12'h000
`define ASAC_DATA_OFS      12'h004
`define ASAC_RS_BIT        2
// Configuration register fields
`define ASAC_CTRL_W        9
`define ASAC_CTRL_RST      9'h003
`define ASAC_DIV_MSB       1
`define ASAC_DIV_LSB       0
`define ASAC_LEN8_BIT      2
`define ASAC_STOP2_BIT     3
`define ASAC_PAREN_BIT     4
`define ASAC_TXC_MSB       6
`define ASAC_TXC_LSB       5
`define ASAC_RIE_BIT       7
`define ASAC_PODD_BIT      8
// Divide-select codes
`define ASAC_DIV_BY1       2'h0
`define ASAC_DIV_BY16      2'h1
`define ASAC_DIV_BY64      2'h2
`define ASAC_DIV_MRESET    2'h3
// Transmit-control codes
`define ASAC_TXC_TIE       2'h1
`define ASAC_TXC_RTS_HIGH  2'h2
`define ASAC_TXC_BREAK     2'h3
// Clock periods per bit and start-bit hunt lengths
`define ASAC_PER1          7'h01
`define ASAC_PER16         7'h10
`define ASAC_PER64         7'h40
`define ASAC_HUNT1         6'h01
`define ASAC_HUNT16        6'h08
`define ASAC_HUNT64        6'h20
// Status register bits
`define ASAC_ST_RX_HOLDING_FULL_FLAG       0
`define ASAC_ST_TX_HOLDING_EMPTY_FLAG       1
`define ASAC_ST_FE         4
`define ASAC_ST_OVR        5
`define ASAC_ST_PE         6
`define ASAC_ST_IRQ        7
`endif

// file: verilog/asac_pkg.sv
package asac_pkg;
    typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_PAR, RX_STOP} asac_rx_st_t;
    typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_PAR, TX_STOP} asac_tx_st_t;
    typedef logic [7:0] asac_byte_t;
endpackage : asac_pkg

// file: verilog/asac_rx_if.sv
`timescale 1ns/100ps
interface asac_rx_if;
    import asac_pkg::*;
    logic       tick;
    logic       line;
    logic       mreset;
    logic       len8;
    logic       par_en;
    logic       par_odd;
    logic [6:0] period;
    logic [5:0] hunt;
    logic       done;
    asac_byte_t data;
    logic       fe;
    logic       pe;
    modport ctl (output tick, line, mreset, len8, par_en, par_odd, period, hunt,
                 input  done, data, fe, pe);
    modport rx  (input  tick, line, mreset, len8, par_en, par_odd, period, hunt,
                 output done, data, fe, pe);
endinterface : asac_rx_if

// file: verilog/asac_rx.sv
`timescale 1ns/100ps
`include "asac_consts.svh"
module asac_rx
    import asac_pkg::*;
(
    input  wire logic clk_in,   // System clock
    input  wire logic rst_n_in, // Async reset, active low
    asac_rx_if.rx     rx_if     // Receive control and result
);
    asac_rx_st_t st_q;
    logic [6:0]  ph_q;
    logic [5:0]  low_q;
    logic [2:0]  idx_q;
    asac_byte_t  sh_q;
    logic        par_q;
    logic        done_q;
    asac_byte_t  data_q;
    logic        fe_q;
    logic        pe_q;
    logic        sample;
    logic        sync;
    logic [2:0]  last_idx;

    assign last_idx = rx_if.len8 ? 3'h7 : 3'h6;
    // [RULE23] centre sampling
    assign sample = rx_if.tick && (st_q != RX_IDLE) && (ph_q == 7'(rx_if.period - 7'h01));
    // [RULE13] hunt count reached
    assign sync = rx_if.tick && (st_q == RX_IDLE) && !rx_if.line
                  && (6'(low_q + 6'h01) == rx_if.hunt);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q  <= RX_IDLE;
            ph_q  <= 7'h00;
            low_q <= 6'h00;
            idx_q <= 3'h0;
            sh_q  <= 8'h00;
            par_q <= 1'b0;
        end else if (rx_if.mreset) begin
            st_q  <= RX_IDLE;
            ph_q  <= 7'h00;
            low_q <= 6'h00;
        end else if (rx_if.tick) begin
            ph_q <= (st_q == RX_IDLE || sample) ? 7'h00 : 7'(ph_q + 7'h01);
            unique case (st_q)
                RX_IDLE: begin
                    // [RULE14] high line drops a false start
                    if (rx_if.line) begin
                        low_q <= 6'h00;
                    end else if (sync) begin
                        // [RULE12] divide-by-one needs no hunt
                        st_q  <= RX_DATA;
                        low_q <= 6'h00;
                        idx_q <= 3'h0;
                        par_q <= 1'b0;
                    end else begin
                        low_q <= 6'(low_q + 6'h01);
                    end
                end
                RX_DATA: begin
                    if (sample) begin
                        sh_q  <= {rx_if.line, sh_q[7:1]};
                        par_q <= par_q ^ rx_if.line;
                        idx_q <= 3'(idx_q + 3'h1);
                        if (idx_q == last_idx) begin
                            st_q <= rx_if.par_en ? RX_PAR : RX_STOP;
                        end
                    end
                end
                RX_PAR: begin
                    if (sample) begin
                        par_q <= par_q ^ rx_if.line;
                        st_q  <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (sample) begin
                        st_q <= RX_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_q <= 1'b0;
            data_q <= 8'h00;
            fe_q   <= 1'b0;
            pe_q   <= 1'b0;
        end else begin
            done_q <= sample && (st_q == RX_STOP) && !rx_if.mreset;
            if (sample && st_q == RX_STOP) begin
                // [RULE17] seven-bit words return a zero top bit
                data_q <= rx_if.len8 ? sh_q : {1'b0, sh_q[7:1]};
                // [RULE24] low first stop bit
                fe_q   <= !rx_if.line;
                // [RULE15] parity check
                pe_q   <= rx_if.par_en && (par_q ^ rx_if.par_odd);
            end
        end
    end

    assign rx_if.done = done_q;
    assign rx_if.data = data_q;
    assign rx_if.fe   = fe_q;
    assign rx_if.pe   = pe_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    hunt_lock_a: assert property (sync && !rx_if.mreset |=> st_q == RX_DATA) // [RULE13]
        else $error("start hunt did not lock");
    false_start_a: assert property ( // [RULE14]
        rx_if.tick && st_q == RX_IDLE && rx_if.line && !rx_if.mreset |=> st_q == RX_IDLE && low_q == 6'h00)
        else $error("false start not rejected");
    frame_err_a: assert property ( // [RULE24]
        sample && st_q == RX_STOP && !rx_if.line && !rx_if.mreset |=> done_q && fe_q)
        else $error("framing error missed");
    strip_a: assert property (done_q && !rx_if.len8 |-> !data_q[7]) // [RULE17]
        else $error("top data bit not stripped");
    false_start_c: cover property (rx_if.tick && st_q == RX_IDLE && low_q != 6'h00 && rx_if.line);
endmodule : asac_rx

// file: verilog/asac_top.sv
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "asac_consts.svh"
// Summary of operation
// [RULE1] Two host locations back four internal registers.
// [RULE2] Status and receive data read only; configuration and transmit data write only.
// [RULE3] Host issues master reset first after power-up.
// [RULE4] First master reset holds interrupt and request-to-send outputs high.
// [RULE5] Later master resets hold interrupt high; request-to-send follows programming.
// [RULE6] Host also writes transmit control when it issues master reset.
// [RULE7] Configuration selects divide ratio, word length, stop bits and parity.
// [RULE8] Host writes a character only after seeing transmit holding empty.
// [RULE9] Characters go out with one start and one or two stop bits.
// [RULE10] Optional parity bit sits between last data bit and first stop.
// [RULE11] A second character waits and loads when the first completes.
// [RULE12] Divide-by-one needs external sync; 16 and 64 synchronise internally.
// [RULE13] Hunt needs 8 low samples in divide-by-16, 32 in divide-by-64.
// [RULE14] False starts rejected; timing locks after half a start bit.
// [RULE15] Parity, framing, overrun and receive-full shown in status.
// [RULE16] A data read returns the received character on the bus.
// [RULE17] Seven-bit words with parity return a zero top bit.
// [RULE18] Receiver double buffered: holding register plus shift register.
// [RULE19] Accesses honoured only with both selects high and third low.
// [RULE20] Register select high reaches data, low reaches control and status.
// [RULE21] Divide field: 00 by 1, 01 by 16, 10 by 64, 11 reset.
// [RULE22] Transmit launches on falling clock edge; receive samples on rising edge.
// [RULE23] After sync each bit sampled once per period near its centre.
// [RULE24] Low first stop bit sets the framing error.
module asac_top
    import asac_pkg::*;
(
    input  wire logic        MCLK_IN,          // System clock
    input  wire logic        RST_N_IN,         // Async reset, active low
    input  wire logic        PSEL_IN,          // APB select
    input  wire logic        PENABLE_IN,       // APB access phase
    input  wire logic        PWRITE_IN,        // APB direction
    input  wire logic [11:0] PADDR_IN,         // APB byte address
    input  wire logic [31:0] PWDATA_IN,        // APB write data
    output logic      [31:0] PRDATA_OUT,       // APB read data
    output logic             PREADY_OUT,       // APB ready
    output logic             PSLVERR_OUT,      // APB error
    input  wire logic        CHIP_SELECT_A_IN, // Select, active high
    input  wire logic        CHIP_SELECT_B_IN, // Select, active high
    input  wire logic        CHIP_SELECT_N_IN, // Select, active low
    input  wire logic        TX_CLK_IN,        // Transmit bit clock
    input  wire logic        RX_CLK_IN,        // Receive bit clock
    input  wire logic        RX_DATA_IN,       // Serial receive line
    output logic             TX_DATA_OUT,      // Serial transmit line
    output logic             RTS_N_OUT,        // Request to send, active low
    output logic             IRQ_N_OUT         // Interrupt request, active low
);
    asac_rx_if rx_if ();

    logic [`ASAC_CTRL_W-1:0] ctrl_q;
    logic        first_q;
    logic        txc_prev_q;
    logic        rxc_prev_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    asac_byte_t  rxd_q;
    logic        rx_holding_full_flag_q;
    logic        ovr_q;
    logic        fe_q;
    logic        pe_q;
    asac_byte_t  txh_q;
    logic        tx_holding_empty_flag_q;
    asac_tx_st_t tx_st_q;
    asac_byte_t  tsh_q;
    logic [6:0]  tdiv_q;
    logic [2:0]  tidx_q;
    logic        tstop_q;
    logic        tpar_q;
    logic        txd_q;
    logic        tx_out_q;
    logic        rts_n_q;
    logic        irq_n_q;

    logic [1:0]  div;
    logic [1:0]  txc;
    logic        mreset;
    logic [6:0]  per;
    logic [5:0]  hunt;
    logic        cs_ok;
    logic        addr_ok;
    logic        rs;
    logic        setup;
    logic        acc_done;
    logic        wr_ctrl;
    logic        wr_tx;
    logic        rd_rx;
    logic        tx_tick;
    logic        tx_bnd;
    logic        tx_load;
    logic [2:0]  tlast;
    logic        irq_cond;
    asac_byte_t  status;

    assign div    = ctrl_q[`ASAC_DIV_MSB:`ASAC_DIV_LSB];
    assign txc    = ctrl_q[`ASAC_TXC_MSB:`ASAC_TXC_LSB];
    // [RULE21] code 11 holds the block in reset
    assign mreset = (div == `ASAC_DIV_MRESET);

    // [RULE21] one ratio for both directions
    always_comb begin
        unique case (div)
            `ASAC_DIV_BY16: begin
                per  = `ASAC_PER16;
                hunt = `ASAC_HUNT16;
            end
            `ASAC_DIV_BY64: begin
                per  = `ASAC_PER64;
                hunt = `ASAC_HUNT64;
            end
            `ASAC_DIV_BY1, `ASAC_DIV_MRESET: begin
                per  = `ASAC_PER1;
                hunt = `ASAC_HUNT1;
            end
        endcase
    end

    // [RULE19] three-way chip select
    assign cs_ok    = CHIP_SELECT_A_IN && CHIP_SELECT_B_IN && !CHIP_SELECT_N_IN;
    // [RULE1] only two locations decode
    assign addr_ok  = (PADDR_IN == `ASAC_CTRL_STAT_OFS) || (PADDR_IN == `ASAC_DATA_OFS);
    assign rs       = PADDR_IN[`ASAC_RS_BIT];
    assign setup    = PSEL_IN && !PENABLE_IN;
    assign acc_done = PSEL_IN && PENABLE_IN && pready_q && cs_ok && addr_ok;
    // [RULE20] select and direction pick one of four
    assign wr_ctrl  = acc_done && PWRITE_IN && !rs;
    assign wr_tx    = acc_done && PWRITE_IN && rs;
    assign rd_rx    = acc_done && !PWRITE_IN && rs;

    // [RULE15] status layout
    always_comb begin
        status                = 8'h00;
        status[`ASAC_ST_RX_HOLDING_FULL_FLAG] = rx_holding_full_flag_q;
        status[`ASAC_ST_TX_HOLDING_EMPTY_FLAG] = tx_holding_empty_flag_q && !mreset;
        status[`ASAC_ST_FE]   = fe_q;
        status[`ASAC_ST_OVR]  = ovr_q;
        status[`ASAC_ST_PE]   = pe_q;
        status[`ASAC_ST_IRQ]  = !irq_n_q;
    end

    // No wait state; read data is registered during the setup phase
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && !addr_ok;
            // [RULE2] reads see only the read-only pair
            if (setup && cs_ok && addr_ok && !PWRITE_IN) begin
                // [RULE16] receive character onto the bus
                prdata_q <= {24'h00_0000, rs ? rxd_q : status};
            end else begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // [RULE7] configuration register
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ctrl_q <= `ASAC_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= PWDATA_IN[`ASAC_CTRL_W-1:0];
        end
    end

    // Power-up counts as the first master reset until it is released
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            first_q <= 1'b1;
        end else if (!mreset) begin
            first_q <= 1'b0;
        end
    end

    // [RULE22] edge detection on the bit clocks
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            txc_prev_q <= 1'b1;
            rxc_prev_q <= 1'b1;
        end else begin
            txc_prev_q <= TX_CLK_IN;
            rxc_prev_q <= RX_CLK_IN;
        end
    end

    assign tx_tick = txc_prev_q && !TX_CLK_IN;
    assign tx_bnd  = tx_tick && (tdiv_q == 7'h00) && !mreset;
    assign tx_load = tx_bnd && (tx_st_q == TX_IDLE) && !tx_holding_empty_flag_q;
    assign tlast   = ctrl_q[`ASAC_LEN8_BIT] ? 3'h7 : 3'h6;

    // Transmit bit-time divider
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tdiv_q <= 7'h00;
        end else if (mreset) begin
            tdiv_q <= 7'h00;
        end else if (tx_tick) begin
            tdiv_q <= (tdiv_q == 7'(per - 7'h01)) ? 7'h00 : 7'(tdiv_q + 7'h01);
        end
    end

    // Holding register; a write beats a same-cycle load so no character is lost
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            txh_q  <= 8'h00;
            tx_holding_empty_flag_q <= 1'b1;
        end else if (mreset) begin
            tx_holding_empty_flag_q <= 1'b1;
        end else if (wr_tx) begin
            txh_q  <= PWDATA_IN[7:0];
            tx_holding_empty_flag_q <= 1'b0;
        // [RULE11] holding register empties into the shifter
        end else if (tx_load) begin
            tx_holding_empty_flag_q <= 1'b1;
        end
    end

    // Transmit shifter
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tx_st_q <= TX_IDLE;
            tsh_q   <= 8'h00;
            tidx_q  <= 3'h0;
            tstop_q <= 1'b0;
            tpar_q  <= 1'b0;
            txd_q   <= 1'b1;
        end else if (mreset) begin
            tx_st_q <= TX_IDLE;
            txd_q   <= 1'b1;
        end else if (tx_bnd) begin
            unique case (tx_st_q)
                TX_IDLE: begin
                    // [RULE9] start bit
                    if (tx_load) begin
                        tsh_q   <= txh_q;
                        tidx_q  <= 3'h0;
                        tpar_q  <= ctrl_q[`ASAC_PODD_BIT];
                        txd_q   <= 1'b0;
                        tx_st_q <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    txd_q  <= tsh_q[0];
                    tsh_q  <= {1'b0, tsh_q[7:1]};
                    tpar_q <= tpar_q ^ tsh_q[0];
                    tidx_q <= 3'(tidx_q + 3'h1);
                    if (tidx_q == tlast) begin
                        tstop_q <= 1'b0;
                        tx_st_q <= ctrl_q[`ASAC_PAREN_BIT] ? TX_PAR : TX_STOP;
                    end
                end
                // [RULE10] parity after the last data bit
                TX_PAR: begin
                    txd_q   <= tpar_q;
                    tx_st_q <= TX_STOP;
                end
                // [RULE9] one or two stop bits
                TX_STOP: begin
                    txd_q <= 1'b1;
                    if (tstop_q || !ctrl_q[`ASAC_STOP2_BIT]) begin
                        tx_st_q <= TX_IDLE;
                    end else begin
                        tstop_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // Receiver hookup
    assign rx_if.tick    = !rxc_prev_q && RX_CLK_IN;
    assign rx_if.line    = RX_DATA_IN;
    assign rx_if.mreset  = mreset;
    assign rx_if.len8    = ctrl_q[`ASAC_LEN8_BIT];
    assign rx_if.par_en  = ctrl_q[`ASAC_PAREN_BIT];
    assign rx_if.par_odd = ctrl_q[`ASAC_PODD_BIT];
    assign rx_if.period  = per;
    assign rx_if.hunt    = hunt;

    asac_rx u_rx (
        .clk_in   (MCLK_IN),
        .rst_n_in (RST_N_IN),
        .rx_if    (rx_if.rx)
    );

    // [RULE18] receive holding register
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rxd_q  <= 8'h00;
            rx_holding_full_flag_q <= 1'b0;
            ovr_q  <= 1'b0;
            fe_q   <= 1'b0;
            pe_q   <= 1'b0;
        end else if (mreset) begin
            rx_holding_full_flag_q <= 1'b0;
            ovr_q  <= 1'b0;
            fe_q   <= 1'b0;
            pe_q   <= 1'b0;
        end else if (rx_if.done) begin
            // [RULE15] overrun keeps the unread character
            if (rx_holding_full_flag_q && !rd_rx) begin
                ovr_q <= 1'b1;
            end else begin
                rxd_q  <= rx_if.data;
                rx_holding_full_flag_q <= 1'b1;
                ovr_q  <= 1'b0;
                fe_q   <= rx_if.fe;
                pe_q   <= rx_if.pe;
            end
        end else if (rd_rx) begin
            rx_holding_full_flag_q <= 1'b0;
            ovr_q  <= 1'b0;
        end
    end

    assign irq_cond = (ctrl_q[`ASAC_RIE_BIT] && (rx_holding_full_flag_q || ovr_q))
                      || (txc == `ASAC_TXC_TIE && tx_holding_empty_flag_q);

    // Pin drivers, all registered
    always_ff @(posedge MCLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tx_out_q <= 1'b1;
            rts_n_q  <= 1'b1;
            irq_n_q  <= 1'b1;
        end else begin
            tx_out_q <= txd_q && !(txc == `ASAC_TXC_BREAK);
            // [RULE4] first reset forces request-to-send high
            rts_n_q  <= (mreset && first_q) || (txc == `ASAC_TXC_RTS_HIGH);
            // [RULE5] interrupt held high during any master reset
            irq_n_q  <= mreset || !irq_cond;
        end
    end

    assign PRDATA_OUT  = prdata_q;
    assign PREADY_OUT  = pready_q;
    assign PSLVERR_OUT = pslverr_q;
    assign TX_DATA_OUT = tx_out_q;
    assign RTS_N_OUT   = rts_n_q;
    assign IRQ_N_OUT   = irq_n_q;

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);

    bad_addr_err_a: assert property (setup && !addr_ok |=> PREADY_OUT && PSLVERR_OUT) // [RULE1]
        else $error("unmapped address not flagged");
    status_read_a: assert property ( // [RULE2]
        setup && cs_ok && !PWRITE_IN && PADDR_IN == `ASAC_CTRL_STAT_OFS
        |=> PRDATA_OUT[7:0] == $past(status))
        else $error("status read wrong");
    rx_read_a: assert property ( // [RULE16]
        setup && cs_ok && !PWRITE_IN && PADDR_IN == `ASAC_DATA_OFS
        |=> PRDATA_OUT == {24'h00_0000, $past(rxd_q)})
        else $error("receive data read wrong");
    cs_gate_a: assert property (PSEL_IN && PENABLE_IN && !cs_ok |=> $stable(ctrl_q)) // [RULE19]
        else $error("write taken while deselected");
    first_rts_a: assert property (mreset && first_q |=> RTS_N_OUT) // [RULE4]
        else $error("request-to-send low in first reset");
    irq_hold_a: assert property (mreset |=> IRQ_N_OUT) // [RULE5]
        else $error("interrupt active during reset");
    tx_start_a: assert property ( // [RULE9]
        tx_load && !wr_ctrl && txc != `ASAC_TXC_BREAK |-> ##2 !TX_DATA_OUT)
        else $error("start bit missing");
    tx_reload_a: assert property (tx_load && !wr_tx |=> tx_holding_empty_flag_q) // [RULE11]
        else $error("holding register not emptied");
    tx_parity_a: assert property ( // [RULE10]
        tx_bnd && tx_st_q == TX_PAR |=> txd_q == $past(tpar_q) && tx_st_q == TX_STOP)
        else $error("parity bit wrong");
    overrun_a: assert property ( // [RULE15]
        rx_if.done && rx_holding_full_flag_q && !rd_rx && !mreset |=> ovr_q && $stable(rxd_q))
        else $error("overrun not flagged");
    mreset_clear_a: assert property (mreset |=> !rx_holding_full_flag_q && !ovr_q && tx_st_q == TX_IDLE) // [RULE21]
        else $error("master reset did not clear");

    tx_char_c: cover property (tx_load ##[1:1000] tx_bnd && tx_st_q == TX_STOP);
    back_to_back_c: cover property (tx_load ##[1:1000] tx_load);
    overrun_c: cover property (rx_if.done && rx_holding_full_flag_q && !rd_rx);
    frame_err_c: cover property (rx_if.done && rx_if.fe);
endmodule : asac_top

// file: tb/asac_peer.sv
`timescale 1ns/100ps
module asac_peer (
    input  wire logic bclk_in,  // Bit clock
    output logic      line_out  // Serial line, idle high
);
    initial line_out = 1'b1;
    // Bits change on the falling edge so the receiver sees them settled
    // Each bit stands for per clock periods, to match the divide ratio
    task automatic send(input logic [10:0] frame, input int per);
        for (int i = 0; i < 11; i++) begin
            repeat (per) @(negedge bclk_in);
            line_out <= frame[i];
        end
        repeat (per) @(negedge bclk_in);
        line_out <= 1'b1;
    endtask : send
endmodule : asac_peer

// file: tb/asac_top_tb.sv
`timescale 1ns/100ps
module asac_top_tb;
    logic        mclk, rst_n, psel, pen, pwr, cs_a, cs_b, cs_n, bclk, rxd;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, txd, rts_n, irq_n, er;
    logic [1:0]  bdiv;
    logic [9:0]  fr;
    int          err_count, total_checks, cyc;
    asac_top u_asac_top (.MCLK_IN(mclk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
        .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .CHIP_SELECT_A_IN(cs_a),
        .CHIP_SELECT_B_IN(cs_b), .CHIP_SELECT_N_IN(cs_n), .TX_CLK_IN(bclk), .RX_CLK_IN(bclk),
        .RX_DATA_IN(rxd), .TX_DATA_OUT(txd), .RTS_N_OUT(rts_n), .IRQ_N_OUT(irq_n));
    asac_peer u_asac_peer (.bclk_in(bclk), .line_out(rxd));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Bit clock at one eighth of the system clock
    always @(posedge mclk) begin
        bdiv <= bdiv + 2'h1;
        if (bdiv == 2'h3) bclk <= ~bclk;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        pen <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    initial begin
        rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 12'h000; pwdata = 32'h0;
        cs_a = 1'b1; bclk = 1'b0; bdiv = 2'h0; cyc = 0; err_count = 0; total_checks = 0;
        cs_b = 1'b1; cs_n = 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        chk({30'h0, rts_n, irq_n}, 32'h3);
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0);
        apb(1'b1, 12'h000, 32'h043); chk({31'h0, rts_n}, 32'h1);
        apb(1'b1, 12'h000, 32'h194); chk({31'h0, er}, 32'h0);
        repeat (2) @(posedge mclk);
        chk({31'h0, rts_n}, 32'h0);
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h2);
        apb(1'b0, 12'h008, 32'h0); chk({31'h0, er}, 32'h1);
        cs_a <= 1'b0;
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0);
        cs_a <= 1'b1; cs_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0);
        cs_n <= 1'b0; cs_b <= 1'b0;
        apb(1'b1, 12'h000, 32'h003);
        cs_b <= 1'b1;
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h2);
        apb(1'b1, 12'h004, 32'hA5);
        // Hunt for the start bit, then sample mid-bit on rising edges
        for (int n = 0; n < 40 && txd !== 1'b0; n++) @(posedge bclk);
        for (int i = 0; i < 10; i++) begin
            @(posedge bclk);
            fr[i] = txd;
        end
        chk({22'h0, fr}, 32'h3A5);
        u_asac_peer.send({1'b1, 1'b1, 8'h3C, 1'b0}, 1);
        repeat (10) @(posedge mclk);
        chk({31'h0, irq_n}, 32'h0);
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h83);
        apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h3C);
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h2);
        // Bad parity and low stop, then a second character nobody reads
        u_asac_peer.send({1'b0, 1'b0, 8'h81, 1'b0}, 1);
        u_asac_peer.send({1'b1, 1'b1, 8'h42, 1'b0}, 1);
        repeat (10) @(posedge mclk);
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'hF3);
        apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h81);
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h52);
        // Divide by 16, seven bits plus odd parity; a short low pulse first
        apb(1'b1, 12'h000, 32'h191);
        u_asac_peer.send({10'h3FF, 1'b0}, 4);
        u_asac_peer.send({1'b1, 1'b1, 1'b1, 7'h55, 1'b0}, 16);
        repeat (10) @(posedge mclk);
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h83);
        apb(1'b0, 12'h004, 32'h0); chk(rd, 32'h55);
        // Later master reset with the transmit interrupt selected
        apb(1'b1, 12'h000, 32'h023);
        repeat (2) @(posedge mclk);
        chk({30'h0, rts_n, irq_n}, 32'h1);
        report_and_stop();
    end
endmodule : asac_top_tb
